//--- core/atim_ctrl.sv
// module: adc trigger, sampling and input mode control behind an apb port
// Operation
// - suspend blocks new conversion triggers
// - update-ready interrupt only when enabled
// - update-ready reads one when updates safe
// - update-ready needs suspend and idle cores
// - sample bit sets sampling, clear holds
// - sample bit overrides sample-time count
// - sample bit drives shared core only
// - request converts input chosen by select
// - request bit self-clears next cycle
// - global trigger fires selected inputs
// - differential bit per upper input
// - signed format bit per upper input
// - two mode bits packed per input
// - smallest package lacks upper mode bits
`timescale 1ns/10ps
`default_nettype none

module atim_ctrl
   import atim_pkg::*;
#(
   parameter int unsigned NUM_CORES = 8,
   parameter bit          SMALL_PKG = 1'b0
)
(
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   // converter side
   input  wire logic [NUM_CORES-1:0] core_busy,
   input  wire logic [31:0]          hw_input_trig,
   input  wire logic                 hw_scan_trig,
   output atim_trig_s                conv_trig,
   output logic                      shared_sample_hold,
   output logic                      sample_time_ignore,
   output logic [15:0]               input_differential_mode,
   output logic [15:0]               input_signed_format,
   output logic                      irq
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   atim_apb_st_e apb_st_r;
   logic         pready_r;
   logic [31:0]  prdata_r;
   logic         pslverr_r;
   atim_ctl3_s   ctl_r;
   logic [31:0]  imode_r;
   logic [1:0]   sts_r;
   logic [1:0]   msk_r;
   logic [31:0]  gsel_r;
   logic         ssel_r;
   logic         upd_prev_r;
   logic         shared_r;
   logic         irq_r;
   logic         wr_go;
   logic         rd_go;
   logic         upd_rise;
   logic [1:0]   sts_set;
   logic [31:0]  imode_keep;
   atim_ctl3_s   wr_ctl;

   // address decode, used for read mux and write strobes
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_addr);
      addr_hit = (a == reg_addr);
   endfunction : addr_hit

   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = addr_hit(a, ATIM_ADDR_CTL3) | addr_hit(a, ATIM_ADDR_IMODE)
                  | addr_hit(a, ATIM_ADDR_STS)  | addr_hit(a, ATIM_ADDR_MSK)
                  | addr_hit(a, ATIM_ADDR_GSEL) | addr_hit(a, ATIM_ADDR_SSEL);
   endfunction : addr_mapped

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, write lands at the edge pready is seen high

   assign rd_go = (apb_st_r == ATIM_APB_IDLE) & psel & penable & ~pwrite;
   assign wr_go = (apb_st_r == ATIM_APB_RESP) & psel & penable & pwrite & pready_r
                & addr_mapped(paddr);
   assign wr_ctl = atim_ctl3_s'(pwdata);

   // phase tracking and response flags
   always_ff @(posedge core_clk) begin
      if (rst) begin
         apb_st_r  <= ATIM_APB_IDLE;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         case (apb_st_r)
            ATIM_APB_IDLE: begin
               if (psel && penable) begin
                  apb_st_r  <= ATIM_APB_RESP;
                  pready_r  <= 1'b1;
                  pslverr_r <= ~addr_mapped(paddr);
               end
            end
            ATIM_APB_RESP: begin
               apb_st_r  <= ATIM_APB_IDLE;
               pready_r  <= 1'b0;
               pslverr_r <= 1'b0;
            end
            default: begin
               apb_st_r  <= ATIM_APB_IDLE;
               pready_r  <= 1'b0;
               pslverr_r <= 1'b0;
            end
         endcase
      end
   end

   // read data captured at the same edge pready rises; unmapped reads zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata_r <= 32'h0000_0000;
      end else if (rd_go) begin
         if (addr_hit(paddr, ATIM_ADDR_CTL3)) begin
            prdata_r <= 32'(ctl_r);
         end else if (addr_hit(paddr, ATIM_ADDR_IMODE)) begin
            prdata_r <= imode_r;
         end else if (addr_hit(paddr, ATIM_ADDR_STS)) begin
            prdata_r <= {30'h0000_0000, sts_r};
         end else if (addr_hit(paddr, ATIM_ADDR_MSK)) begin
            prdata_r <= {30'h0000_0000, msk_r};
         end else if (addr_hit(paddr, ATIM_ADDR_GSEL)) begin
            prdata_r <= gsel_r;
         end else if (addr_hit(paddr, ATIM_ADDR_SSEL)) begin
            prdata_r <= {31'h0000_0000, ssel_r};
         end else begin
            prdata_r <= 32'h0000_0000;
         end
      end else if (!psel) begin
         prdata_r <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // adc_control_three

   // software fields; reserved bits and update-ready are not writable
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctl_r <= atim_ctl3_s'(ATIM_CTL3_RST);
      end else begin
         // request clears the cycle after it was set
         ctl_r.single_conversion_request <= 1'b0;
         // ready only while suspended with idle cores
         ctl_r.update_ready <= ctl_r.trigger_suspend & ~(|core_busy);
         if (wr_go && addr_hit(paddr, ATIM_ADDR_CTL3)) begin
            ctl_r.trigger_suspend           <= wr_ctl.trigger_suspend;
            ctl_r.update_ready_irq_enable   <= wr_ctl.update_ready_irq_enable;
            ctl_r.software_sample_hold      <= wr_ctl.software_sample_hold;
            // writing one requests; zero does nothing
            ctl_r.single_conversion_request <= wr_ctl.single_conversion_request;
            ctl_r.global_level_soft_trigger <= wr_ctl.global_level_soft_trigger;
            ctl_r.request_input_select      <= wr_ctl.request_input_select;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software sampling of the shared sample-and-hold

   // sampling follows the bit, hold when clear
   // bit wins and sample-time count is bypassed
   // only the shared core sees this; class 1 inputs are not wired here
   always_ff @(posedge core_clk) begin
      if (rst) begin
         shared_r <= 1'b0;
      end else begin
         shared_r <= ctl_r.software_sample_hold;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input mode register for inputs 16 to 31

   // absent bits stay zero in the smallest package
   assign imode_keep = SMALL_PKG ? ATIM_IMODE_SMALL_MASK : 32'hFFFF_FFFF;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         imode_r <= ATIM_IMODE_RST;
      end else if (wr_go && addr_hit(paddr, ATIM_ADDR_IMODE)) begin
         imode_r <= pwdata & imode_keep;
      end
   end

   // odd bit differential, even bit signed
   for (genvar g = 0; g < 16; g++) begin : g_mode
      assign input_differential_mode[g] = imode_r[2*g+1];
      assign input_signed_format[g]     = imode_r[2*g];
   end

   ////////////////////////////////////////////////////////////////////////////
   // global soft trigger routing, chosen per input and for the scan

   always_ff @(posedge core_clk) begin
      if (rst) begin
         gsel_r <= ATIM_GSEL_RST;
         ssel_r <= ATIM_SSEL_RST;
      end else begin
         if (wr_go && addr_hit(paddr, ATIM_ADDR_GSEL)) begin
            gsel_r <= pwdata;
         end
         if (wr_go && addr_hit(paddr, ATIM_ADDR_SSEL)) begin
            ssel_r <= pwdata[0];
         end
      end
   end

   // global trigger reaches selected inputs and scan
   atim_trig_gate u_gate (
      .core_clk                  (core_clk),
      .rst                       (rst),
      .trigger_suspend           (ctl_r.trigger_suspend),
      .hw_input_trig             (hw_input_trig),
      .hw_scan_trig              (hw_scan_trig),
      .global_level_soft_trigger (ctl_r.global_level_soft_trigger),
      .glsw_input_select         (gsel_r),
      .glsw_scan_select          (ssel_r),
      .single_conversion_request (ctl_r.single_conversion_request),
      .request_input_select      (ctl_r.request_input_select),
      .trig_r                    (conv_trig)
   );

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status, mask and output

   // edge of update-ready, not its level
   assign upd_rise = ctl_r.update_ready & ~upd_prev_r;

   always_comb begin
      sts_set = 2'h0;
      // no event unless the enable is set
      sts_set[ATIM_STS_UPD_BIT] = upd_rise & ctl_r.update_ready_irq_enable;
      sts_set[ATIM_STS_REQ_BIT] = conv_trig.single_trig;
   end

   // sticky status, write one to clear; a set in the same cycle wins
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sts_r      <= ATIM_STS_RST;
         msk_r      <= ATIM_MSK_RST;
         upd_prev_r <= 1'b0;
      end else begin
         upd_prev_r <= ctl_r.update_ready;
         if (wr_go && addr_hit(paddr, ATIM_ADDR_STS)) begin
            sts_r <= (sts_r & ~pwdata[1:0]) | sts_set;
         end else begin
            sts_r <= sts_r | sts_set;
         end
         if (wr_go && addr_hit(paddr, ATIM_ADDR_MSK)) begin
            msk_r <= pwdata[1:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(sts_r & msk_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign pready             = pready_r;
   assign prdata             = prdata_r;
   assign pslverr            = pslverr_r;
   assign shared_sample_hold = shared_r;
   assign sample_time_ignore = shared_r;
   assign irq                = irq_r;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence s_upd_event;
      $rose(ctl_r.update_ready) && ctl_r.update_ready_irq_enable;
   endsequence

   sequence s_request;
      ctl_r.single_conversion_request && !ctl_r.trigger_suspend;
   endsequence

   property p_susp_block;
      ctl_r.trigger_suspend |=> (conv_trig.input_trig == 32'h0000_0000)
                                && !conv_trig.scan_trig && !conv_trig.single_trig;
   endproperty
   a_susp_block: assert property (p_susp_block) else $error("trigger passed while suspended");

   property p_irq_on_update;
      s_upd_event |=> sts_r[ATIM_STS_UPD_BIT] ##1 (irq_r || !$past(msk_r[ATIM_STS_UPD_BIT]));
   endproperty
   a_irq_on_update: assert property (p_irq_on_update) else $error("no irq after update-ready");

   property p_no_sts_without_en;
      !ctl_r.update_ready_irq_enable && !sts_r[ATIM_STS_UPD_BIT]
         |=> !sts_r[ATIM_STS_UPD_BIT];
   endproperty
   a_no_sts_without_en: assert property (p_no_sts_without_en) else $error("update flag while disabled");

   property p_ready_cause;
      $rose(ctl_r.update_ready) |-> $past(ctl_r.trigger_suspend) && ($past(core_busy) == '0);
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("update-ready without idle suspend");

   property p_ready_drop;
      ctl_r.update_ready && (|core_busy) |=> !ctl_r.update_ready;
   endproperty
   a_ready_drop: assert property (p_ready_drop) else $error("update-ready held while busy");

   property p_sample_held;
      ctl_r.software_sample_hold [*3] |=> shared_sample_hold && sample_time_ignore;
   endproperty
   a_sample_held: assert property (p_sample_held) else $error("sampling not held");

   property p_hold_on_clear;
      $fell(ctl_r.software_sample_hold) |=> !shared_sample_hold;
   endproperty
   a_hold_on_clear: assert property (p_hold_on_clear) else $error("no hold after clear");

   property p_req_selfclear;
      ctl_r.single_conversion_request |=> !ctl_r.single_conversion_request;
   endproperty
   a_req_selfclear: assert property (p_req_selfclear) else $error("request bit stuck");

   property p_req_converts;
      s_request |=> conv_trig.single_trig
                    && (conv_trig.single_sel == $past(ctl_r.request_input_select));
   endproperty
   a_req_converts: assert property (p_req_converts) else $error("request did not trigger");

   property p_glsw_routes;
      ctl_r.global_level_soft_trigger && !ctl_r.trigger_suspend
         |=> ((conv_trig.input_trig & $past(gsel_r)) == $past(gsel_r));
   endproperty
   a_glsw_routes: assert property (p_glsw_routes) else $error("global trigger missed input");

   property p_pack_28;
      input_differential_mode[12] == imode_r[25];
   endproperty
   a_pack_28: assert property (p_pack_28) else $error("input 28 mode bit misplaced");

   property p_small_absent;
      SMALL_PKG |-> ((imode_r & ~ATIM_IMODE_SMALL_MASK) == 32'h0000_0000);
   endproperty
   a_small_absent: assert property (p_small_absent) else $error("absent mode bit set");

endmodule : atim_ctrl
`default_nettype wire

//--- core/atim_pkg.sv
// package: register map, field layouts, reset values and types of the adc trigger control
package atim_pkg;

   // clock rate of the converter clock
   localparam int unsigned ATIM_CLK_HZ = 40_000_000;

   // register byte offsets on the apb port
   localparam logic [7:0] ATIM_ADDR_CTL3  = 8'h00;
   localparam logic [7:0] ATIM_ADDR_IMODE = 8'h04;
   localparam logic [7:0] ATIM_ADDR_STS   = 8'h08;
   localparam logic [7:0] ATIM_ADDR_MSK   = 8'h0C;
   localparam logic [7:0] ATIM_ADDR_GSEL  = 8'h10;
   localparam logic [7:0] ATIM_ADDR_SSEL  = 8'h14;

   // reset values
   localparam logic [31:0] ATIM_CTL3_RST  = 32'h0000_0000;
   localparam logic [31:0] ATIM_IMODE_RST = 32'h0000_0000;
   localparam logic [1:0]  ATIM_STS_RST   = 2'h0;
   localparam logic [1:0]  ATIM_MSK_RST   = 2'h0;
   localparam logic [31:0] ATIM_GSEL_RST  = 32'h0000_0000;
   localparam logic        ATIM_SSEL_RST  = 1'b0;

   // bits of the input mode register that exist in the smallest package
   localparam logic [31:0] ATIM_IMODE_SMALL_MASK = 32'h0000_003F;

   // status and mask bit positions
   localparam int unsigned ATIM_STS_UPD_BIT = 0;
   localparam int unsigned ATIM_STS_REQ_BIT = 1;

   // adc_control_three layout, bit 31 down to bit 0
   typedef struct packed {
      logic [18:0] rsvd_hi;
      logic        trigger_suspend;
      logic        update_ready_irq_enable;
      logic        update_ready;
      logic        software_sample_hold;
      logic        single_conversion_request;
      logic        global_level_soft_trigger;
      logic        rsvd_6;
      logic [5:0]  request_input_select;
   } atim_ctl3_s;

   // trigger bundle handed to the conversion cores
   typedef struct packed {
      logic [31:0] input_trig;
      logic        scan_trig;
      logic        single_trig;
      logic [5:0]  single_sel;
   } atim_trig_s;

   // apb slave phase
   typedef enum logic [0:0] {
      ATIM_APB_IDLE = 1'b0,
      ATIM_APB_RESP = 1'b1
   } atim_apb_st_e;

endpackage : atim_pkg

//--- core/atim_trig_gate.sv
// module: trigger gating and merging toward the conversion cores
`timescale 1ns/10ps
`default_nettype none

module atim_trig_gate
   import atim_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        trigger_suspend,
   input  wire logic [31:0] hw_input_trig,
   input  wire logic        hw_scan_trig,
   input  wire logic        global_level_soft_trigger,
   input  wire logic [31:0] glsw_input_select,
   input  wire logic        glsw_scan_select,
   input  wire logic        single_conversion_request,
   input  wire logic [5:0]  request_input_select,
   output atim_trig_s       trig_r
);

   atim_trig_s trig_nxt;

   // merge hardware, global soft and single triggers
   always_comb begin
      trig_nxt = '0;
      trig_nxt.input_trig = hw_input_trig
                          | (global_level_soft_trigger ? glsw_input_select : 32'h0000_0000);
      trig_nxt.scan_trig   = hw_scan_trig | (global_level_soft_trigger & glsw_scan_select);
      trig_nxt.single_trig = single_conversion_request;
      trig_nxt.single_sel  = request_input_select;
      // suspend blocks triggers
      // the converter stays enabled; only new starts are held off
      if (trigger_suspend) begin
         trig_nxt.input_trig  = 32'h0000_0000;
         trig_nxt.scan_trig   = 1'b0;
         trig_nxt.single_trig = 1'b0;
      end
   end

   // registered so every trigger output comes from a flop
   always_ff @(posedge core_clk) begin
      if (rst) begin
         trig_r <= '0;
      end else begin
         trig_r <= trig_nxt;
      end
   end

endmodule : atim_trig_gate
`default_nettype wire

//--- testbench/atim_core_model.sv
// model of the conversion cores: a core stays busy for a while after each trigger
`timescale 1ns/10ps
`default_nettype none

module atim_core_model
   import atim_pkg::*;
#(
   parameter int unsigned NUM_CORES = 8
)
(
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire atim_trig_s           conv_trig,
   input  wire logic                 slow,
   output logic [NUM_CORES-1:0]      core_busy
);
   logic [NUM_CORES-1:0] start;
   logic [5:0]           cnt_r [NUM_CORES];

   // map every trigger onto a core; single requests go to core single_sel modulo NUM_CORES
   always_comb begin
      start = '0;
      for (int i = 0; i < 32; i++)
         if (conv_trig.input_trig[i]) start[i % NUM_CORES] = 1'b1;
      if (conv_trig.scan_trig) start[0] = 1'b1;
      if (conv_trig.single_trig) start[conv_trig.single_sel % NUM_CORES] = 1'b1;
   end

   // slow mode keeps a core busy long enough to be seen from the register bus
   always_ff @(posedge core_clk) begin
      for (int k = 0; k < NUM_CORES; k++) begin
         if (rst) cnt_r[k] <= 6'h00;
         else if (start[k]) cnt_r[k] <= slow ? 6'h28 : 6'h03;
         else if (cnt_r[k] != 6'h00) cnt_r[k] <= cnt_r[k] - 6'h01;
      end
   end

   // busy while a conversion is still counting down
   always_comb begin
      for (int k = 0; k < NUM_CORES; k++)
         core_busy[k] = (cnt_r[k] != 6'h00);
   end
endmodule : atim_core_model
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for the adc trigger, sampling and input mode control
`timescale 1ns/10ps
`default_nettype none

module tb_top
   import atim_pkg::*;
;
   localparam int unsigned NUM_CORES = 8;
   logic                 core_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic                 hw_scan_trig, slow, shared_sample_hold, sample_time_ignore;
   logic [7:0]           paddr;
   logic [31:0]          pwdata, prdata, hw_input_trig, r;
   logic [NUM_CORES-1:0] core_busy;
   logic [15:0]          input_differential_mode, input_signed_format, d, s;
   logic [5:0]           sel;
   atim_trig_s           conv_trig;
   logic [33:0]          apb_q [$];
   logic [5:0]           sel_q [$];
   int                   errors, check_count;

   atim_ctrl #(.NUM_CORES(NUM_CORES), .SMALL_PKG(1'b0)) u_atim_ctrl (
      .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .core_busy(core_busy), .hw_input_trig(hw_input_trig), .hw_scan_trig(hw_scan_trig),
      .conv_trig(conv_trig), .shared_sample_hold(shared_sample_hold),
      .sample_time_ignore(sample_time_ignore), .input_differential_mode(input_differential_mode),
      .input_signed_format(input_signed_format), .irq(irq));

   atim_core_model #(.NUM_CORES(NUM_CORES)) u_atim_core_model (
      .core_clk(core_clk), .rst(rst), .conv_trig(conv_trig), .slow(slow),
      .core_busy(core_busy));

   ////////////////////////////////////////////////////////////////////////////
   // checking and reporting
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   // one apb transfer; the note {write, slverr, rdata} is queued for the monitor
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat,
                      input logic [32:0] exp);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dat;
      apb_q.push_back({wr, exp});
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         errors++;
         complete_run();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge core_clk); // outputs one flop behind a write have settled
   endtask : apb

   // bounded wait until every core is idle, plus the status register latency
   task automatic wait_idle();
      int n;
      n = 0;
      while (core_busy !== '0 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 100) begin
         errors++;
         complete_run();
      end
      repeat (2) @(posedge core_clk);
   endtask : wait_idle

   task automatic done(input string name);
      $display("test %s done, mismatches so far %0d", name, errors);
   endtask : done

   // completed transfers checked against the oldest note
   always @(posedge core_clk) begin
      logic [33:0] e;
      if (psel && penable && pready === 1'b1) begin
         if (apb_q.size() == 0) chk("apb note", 32'h0000_0000, 32'h0000_0001);
         else begin
            e = apb_q.pop_front();
            chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
            if (!e[33]) chk("prdata", e[31:0], prdata);
         end
      end
   end

   // each single conversion pulse must match a queued request
   always @(posedge core_clk) begin
      if (!rst && conv_trig.single_trig === 1'b1) begin
         if (sel_q.size() == 0) chk("single_trig", 32'h0000_0000, 32'h0000_0001);
         else chk("single_sel", {26'h0, sel_q.pop_front()}, {26'h0, conv_trig.single_sel});
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock and main sequence
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   initial begin
      logic [7:0] addrs [6];
      addrs = '{ATIM_ADDR_CTL3, ATIM_ADDR_IMODE, ATIM_ADDR_STS, ATIM_ADDR_MSK,
                ATIM_ADDR_GSEL, ATIM_ADDR_SSEL};
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      hw_input_trig = 32'h0000_0000;
      hw_scan_trig = 1'b0;
      slow = 1'b0;
      errors = 0;
      check_count = 0;
      void'($urandom(24));
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      // reset values, read-only and reserved bits, unmapped place
      foreach (addrs[i]) apb(1'b0, addrs[i], 32'h0000_0000, 33'h0_0000_0000);
      apb(1'b1, ATIM_ADDR_CTL3, 32'hFFFF_0440, 33'h0_0000_0000);
      apb(1'b0, ATIM_ADDR_CTL3, 32'h0000_0000, 33'h0_0000_0000);
      apb(1'b1, 8'h18, 32'hFFFF_FFFF, 33'h1_0000_0000);
      apb(1'b0, 8'h18, 32'h0000_0000, 33'h1_0000_0000);
      done("registers");
      // input mode packing, random word then input 28 alone
      r = $urandom();
      apb(1'b1, ATIM_ADDR_IMODE, r, 33'h0_0000_0000);
      apb(1'b0, ATIM_ADDR_IMODE, 32'h0000_0000, {1'b0, r});
      for (int k = 0; k < 16; k++) begin
         d[k] = r[2*k+1];
         s[k] = r[2*k];
      end
      chk("diff", {16'h0, d}, {16'h0, input_differential_mode});
      chk("sign", {16'h0, s}, {16'h0, input_signed_format});
      apb(1'b1, ATIM_ADDR_IMODE, 32'h0200_0000, 33'h0_0000_0000);
      chk("diff28", 32'h0000_1000, {16'h0, input_differential_mode});
      chk("sign28", 32'h0000_0000, {16'h0, input_signed_format});
      done("input mode");
      // hardware triggers pass, then suspend blocks them and a single request
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, ATIM_ADDR_CTL3, p ? 32'h0000_1000 : 32'h0000_0000, 33'h0_0000_0000);
         r = $urandom();
         hw_input_trig <= r;
         hw_scan_trig <= 1'b1;
         repeat (3) @(posedge core_clk);
         chk("input_trig", p ? 32'h0000_0000 : r, conv_trig.input_trig);
         chk("scan_trig", {31'h0, p == 0}, {31'h0, conv_trig.scan_trig});
         hw_input_trig <= 32'h0000_0000;
         hw_scan_trig <= 1'b0;
      end
      apb(1'b1, ATIM_ADDR_CTL3, 32'h0000_1123, 33'h0_0000_0000);
      apb(1'b0, ATIM_ADDR_STS, 32'h0000_0000, 33'h0_0000_0000);
      apb(1'b1, ATIM_ADDR_CTL3, 32'h0000_0000, 33'h0_0000_0000);
      done("suspend");
      // global level software trigger over selected inputs and scan
      r = $urandom();
      apb(1'b1, ATIM_ADDR_GSEL, r, 33'h0_0000_0000);
      apb(1'b1, ATIM_ADDR_SSEL, 32'h0000_0001, 33'h0_0000_0000);
      apb(1'b1, ATIM_ADDR_CTL3, 32'h0000_0080, 33'h0_0000_0000);
      chk("glsw inputs", r, conv_trig.input_trig);
      chk("glsw scan", 32'h0000_0001, {31'h0, conv_trig.scan_trig});
      apb(1'b1, ATIM_ADDR_CTL3, 32'h0000_0000, 33'h0_0000_0000);
      chk("glsw off", 32'h0000_0000, conv_trig.input_trig);
      apb(1'b1, ATIM_ADDR_GSEL, 32'h0000_0000, 33'h0_0000_0000);
      apb(1'b1, ATIM_ADDR_SSEL, 32'h0000_0000, 33'h0_0000_0000);
      done("global trigger");
      // software sampling, then single requests at three random inputs and input 63
      apb(1'b1, ATIM_ADDR_CTL3, 32'h0000_0200, 33'h0_0000_0000);
      chk("sampling", 32'h0000_0003, {30'h0, shared_sample_hold, sample_time_ignore});
      // sample bit cleared before any request
      apb(1'b1, ATIM_ADDR_CTL3, 32'h0000_0000, 33'h0_0000_0000);
      chk("holding", 32'h0000_0000, {30'h0, shared_sample_hold, sample_time_ignore});
      for (int i = 0; i < 4; i++) begin
         sel = 6'($urandom());
         if (i == 3) sel = 6'h3F;
         sel_q.push_back(sel);
         apb(1'b1, ATIM_ADDR_CTL3, {23'h0, 1'b1, 2'h0, sel}, 33'h0_0000_0000);
         apb(1'b0, ATIM_ADDR_CTL3, 32'h0000_0000, {27'h0, sel});
      end
      apb(1'b1, ATIM_ADDR_CTL3, 32'h0000_0011, 33'h0_0000_0000);
      apb(1'b0, ATIM_ADDR_STS, 32'h0000_0000, 33'h0_0000_0002);
      apb(1'b1, ATIM_ADDR_STS, 32'h0000_0002, 33'h0_0000_0000);
      done("requests");
      // update ready waits for a slow conversion, then interrupts
      slow <= 1'b1;
      sel_q.push_back(6'h07);
      apb(1'b1, ATIM_ADDR_CTL3, 32'h0000_0107, 33'h0_0000_0000);
      apb(1'b1, ATIM_ADDR_CTL3, 32'h0000_1800, 33'h0_0000_0000);
      apb(1'b0, ATIM_ADDR_CTL3, 32'h0000_0000, 33'h0_0000_1800);
      wait_idle();
      apb(1'b0, ATIM_ADDR_CTL3, 32'h0000_0000, 33'h0_0000_1C00);
      apb(1'b0, ATIM_ADDR_STS, 32'h0000_0000, 33'h0_0000_0003);
      chk("irq masked", 32'h0000_0000, {31'h0, irq});
      apb(1'b1, ATIM_ADDR_MSK, 32'h0000_0001, 33'h0_0000_0000);
      repeat (4) @(posedge core_clk);
      chk("irq held", 32'h0000_0001, {31'h0, irq});
      apb(1'b1, ATIM_ADDR_STS, 32'h0000_0001, 33'h0_0000_0000);
      chk("irq cleared", 32'h0000_0000, {31'h0, irq});
      apb(1'b0, ATIM_ADDR_STS, 32'h0000_0000, 33'h0_0000_0002);
      apb(1'b1, ATIM_ADDR_STS, 32'h0000_0002, 33'h0_0000_0000);
      // suspend again with the enable clear: no event recorded
      apb(1'b1, ATIM_ADDR_CTL3, 32'h0000_0000, 33'h0_0000_0000);
      apb(1'b1, ATIM_ADDR_CTL3, 32'h0000_1000, 33'h0_0000_0000);
      wait_idle();
      apb(1'b0, ATIM_ADDR_CTL3, 32'h0000_0000, 33'h0_0000_1400);
      apb(1'b0, ATIM_ADDR_STS, 32'h0000_0000, 33'h0_0000_0000);
      chk("irq idle", 32'h0000_0000, {31'h0, irq});
      slow <= 1'b0;
      done("update ready");
      chk("pending requests", 32'h0000_0000, sel_q.size());
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
